/* core/ood_top.sv */
// Option decoder, program PROM with programmer window, reset sequencer.
// Assumes one AHB-Lite master on hclk and a programmer port synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "ood_map.svh"
module ood_top
  import ood_pkg::*;
#(
  parameter int ROM_KB    = 16,
  parameter int STAB_CYC0 = 16,
  parameter int STAB_CYC1 = 4096,
  parameter int STAB_CYC2 = 65536,
  parameter int STAB_CYC3 = 262144
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Programmer port
  input  wire logic        prog_mode,
  input  wire logic [14:0] prog_addr,
  input  wire logic [7:0]  prog_wdata,
  input  wire logic        prog_we,
  input  wire logic        prog_oe,
  output logic [7:0]       prog_rdata,
  // Reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  // Reset sources and wake
  input  wire logic        wdt_reset_req,
  input  wire logic        wake_req,
  // Decoded configuration and sequencer state
  output logic             single_clock_sel,
  output logic [7:0]       port0_pullup_en,
  output logic [7:0]       port1_pullup_en,
  output logic [7:0]       port3_pullup_en,
  output logic             core_reset_n,
  output logic             stop_mode,
  output logic             osc_stable
);

  localparam int ROM_BYTES = ROM_KB * 1024;
  localparam int AW        = $clog2(ROM_BYTES);
  localparam int CNT_W     = $clog2(STAB_CYC3 + 1);
  localparam logic [15:0] ROM_MASK = 16'(ROM_BYTES - 1);
  localparam bit   HAS_OPT = (ROM_KB != 32);

  // Erased PROM reads all ones; not cleared by reset, like the real cells
  logic [7:0] rom_mem [ROM_BYTES] = '{default: `OOD_ERASED};
  logic [7:0] opt_mem [`OOD_OPT_NUM] = '{default: `OOD_ERASED};

  // Window decode shared by programmer and CPU addresses
  function automatic logic in_window(input logic [15:0] a, input logic [15:0] top);
    in_window = ((a | ROM_MASK) == top);
  endfunction

  function automatic logic [CNT_W-1:0] stab_cycles(input ood_stab_sel_t s);
    case (s)
      OOD_STAB_2E4:  stab_cycles = CNT_W'(STAB_CYC0);
      OOD_STAB_2E12: stab_cycles = CNT_W'(STAB_CYC1);
      OOD_STAB_2E16: stab_cycles = CNT_W'(STAB_CYC2);
      OOD_STAB_2E18: stab_cycles = CNT_W'(STAB_CYC3);
      default:       stab_cycles = CNT_W'(STAB_CYC3);
    endcase
  endfunction

  // Programmer side decode
  wire logic          prog_in_rom;
  wire logic          prog_in_opt;
  wire logic [AW-1:0] prog_idx;
  wire logic [2:0]    opt_idx;
  wire logic [7:0]    prog_rd_val;

  assign prog_in_rom = in_window({1'b0, prog_addr}, {1'b0, `OOD_PADDR_TOP});
  assign prog_idx    = prog_addr[AW-1:0];
  assign prog_in_opt = HAS_OPT && (prog_addr >= `OOD_OPT_BASE) && (prog_addr <= `OOD_OPT_LAST);
  assign opt_idx     = 3'(prog_addr - `OOD_OPT_BASE);
  // Plain memory read only; no signature pattern is ever returned
  assign prog_rd_val = prog_in_rom ? rom_mem[prog_idx] :
                       prog_in_opt ? opt_mem[opt_idx] : `OOD_ERASED;

  // One-time cells: programming only clears bits
  always_ff @(posedge hclk)
  begin
    if (prog_mode && prog_we && prog_in_rom)
      rom_mem[prog_idx] <= rom_mem[prog_idx] & prog_wdata;
    if (prog_mode && prog_we && prog_in_opt)
      opt_mem[opt_idx] <= opt_mem[opt_idx] & prog_wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prog_rdata <= `OOD_ERASED;
    else if (prog_mode && prog_oe)
      prog_rdata <= prog_rd_val;
  end

  // Option capture and decode
  logic [7:0] opt0_reg;
  logic [7:0] opt1_reg;
  logic [7:0] opt2_reg;
  logic [7:0] opt3_reg;
  ood_state_t state_reg;
  ood_state_t state_next;
  wire logic  capture;

  assign capture = (state_reg == OOD_ST_LOAD);

  // Sampled from the cells in the load state, also while the reset pin is held low; hresetn loads all ones
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opt0_reg <= `OOD_ERASED;
      opt1_reg <= `OOD_ERASED;
      opt2_reg <= `OOD_ERASED;
      opt3_reg <= `OOD_ERASED;
    end
    else if (capture)
    begin
      opt0_reg <= HAS_OPT ? opt_mem[0] : `OOD_ERASED;
      opt1_reg <= HAS_OPT ? opt_mem[1] : `OOD_ERASED;
      opt2_reg <= HAS_OPT ? opt_mem[2] : `OOD_ERASED;
      opt3_reg <= HAS_OPT ? opt_mem[3] : `OOD_ERASED;
    end
  end

  // Bytes 4..6 and byte 0 bits 7:5 are never looked at
  wire logic          rst_out_en;
  wire logic          por_en;
  wire ood_stab_sel_t stab_sel;

  assign single_clock_sel = opt0_reg[`OOD_B0_CLK];
  assign rst_out_en       = opt0_reg[`OOD_B0_RSTO];
  assign por_en           = opt0_reg[`OOD_B0_POR];
  assign stab_sel         = ood_stab_sel_t'(opt0_reg[1:0]);
  assign port0_pullup_en  = opt1_reg;
  assign port1_pullup_en  = opt2_reg ^ `OOD_P1_INV_MASK;
  assign port3_pullup_en  = opt3_reg;

  // AHB-Lite slave, zero wait states
  logic [5:0]  ahb_addr_reg;
  logic        ahb_wr_reg;
  logic [15:0] rom_addr_reg;
  logic        stop_req_reg;
  logic        srst_req_reg;
  wire logic   ahb_valid;
  wire logic   ahb_ok;
  wire logic   wr_ctrl;
  wire logic   wr_roma;
  wire logic   cpu_in_rom;
  wire logic [31:0] rd_val;

  assign ahb_valid = hsel && hready && (htrans == `OOD_HTRANS_NSEQ);
  assign ahb_ok    = ahb_valid && (hsize == `OOD_HSIZE_WORD) && (haddr[1:0] == 2'h0);
  assign wr_ctrl   = ahb_wr_reg && (ahb_addr_reg == `OOD_REG_CTRL);
  assign wr_roma   = ahb_wr_reg && (ahb_addr_reg == `OOD_REG_ROMA);
  assign cpu_in_rom = in_window(rom_addr_reg, `OOD_CADDR_TOP);

  assign rd_val =
    (haddr[5:0] == `OOD_REG_OPT)  ? {16'h0, 8'h0, 3'h0, single_clock_sel, rst_out_en, por_en, opt0_reg[1:0]} :
    (haddr[5:0] == `OOD_REG_PULL) ? {8'h0, port3_pullup_en, port1_pullup_en, port0_pullup_en} :
    (haddr[5:0] == `OOD_REG_CTRL) ? {30'h0, srst_req_reg, stop_req_reg} :
    (haddr[5:0] == `OOD_REG_STAT) ? {28'h0, osc_stable, core_reset_n, state_reg} :
    (haddr[5:0] == `OOD_REG_ROMA) ? {16'h0, rom_addr_reg} :
    (haddr[5:0] == `OOD_REG_ROMD) ? {24'h0, cpu_in_rom ? rom_mem[rom_addr_reg[AW-1:0]] : `OOD_ERASED} :
    32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ahb_addr_reg <= 6'h0;
      ahb_wr_reg   <= 1'b0;
      hrdata       <= 32'h0;
    end
    else
    begin
      ahb_addr_reg <= haddr[5:0];
      ahb_wr_reg   <= ahb_ok && hwrite && (haddr[31:6] == 26'h0);
      if (ahb_valid)
        hrdata <= (ahb_ok && !hwrite && (haddr[31:6] == 26'h0)) ? rd_val : 32'h0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Control register; the stop request is held until the sequencer reaches stop, the reset request lasts one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rom_addr_reg <= 16'h0;
      stop_req_reg <= 1'b0;
      srst_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_roma)
        rom_addr_reg <= hwdata[15:0];
      stop_req_reg <= (wr_ctrl && hwdata[`OOD_CTRL_STOP]) ||
                      (stop_req_reg && state_reg != OOD_ST_STOP);
      srst_req_reg <= wr_ctrl && hwdata[`OOD_CTRL_SRST];
    end
  end

  // Reset sources and reset pin
  logic [3:0] rst_out_cnt_reg;
  logic       por_pend_reg;
  wire logic  int_reset;
  wire logic  pin_low_ext;

  assign int_reset   = srst_req_reg | wdt_reset_req;
  assign pin_low_ext = ~rst_pin_i & ~rst_pin_oe;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_out_cnt_reg <= 4'h0;
    else if (int_reset && rst_out_en)
      rst_out_cnt_reg <= `OOD_RST_OUT_CYC;
    else if (rst_out_cnt_reg != 4'h0)
      rst_out_cnt_reg <= rst_out_cnt_reg - 4'h1;
  end

  // Only ever pulls low; the pad pull-up gives the high level
  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = (rst_out_cnt_reg != 4'h0);

  // Power-on option read straight from the cell, as opt0 is loaded this cycle
  function automatic logic opt_mem_por();
    opt_mem_por = HAS_OPT ? opt_mem[0][`OOD_B0_POR] : 1'b1;
  endfunction

  // Sequencer
  wire logic stab_start;
  wire logic stab_busy;
  wire logic stab_done;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      OOD_ST_LOAD: state_next = por_pend_reg && opt_mem_por() ? OOD_ST_STAB : OOD_ST_RUN;
      OOD_ST_STAB: state_next = stab_done ? OOD_ST_RUN : OOD_ST_STAB;
      OOD_ST_RUN:  state_next = stop_req_reg ? OOD_ST_STOP : OOD_ST_RUN;
      OOD_ST_STOP: state_next = wake_req ? OOD_ST_STAB : OOD_ST_STOP;
      default:     state_next = OOD_ST_LOAD;
    endcase
    if (int_reset || pin_low_ext)
      state_next = OOD_ST_LOAD;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg    <= OOD_ST_LOAD;
      por_pend_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      // Kept through the power-on wait so the core stays held in reset
      if (state_reg == OOD_ST_RUN || state_reg == OOD_ST_STOP)
        por_pend_reg <= 1'b0;
    end
  end

  // Wait also applies with an external clock source
  assign stab_start = (state_reg == OOD_ST_LOAD && state_next == OOD_ST_STAB) ||
                      (state_reg == OOD_ST_STOP && state_next == OOD_ST_STAB);

  wire logic [CNT_W-1:0] stab_load;
  assign stab_load = (state_reg == OOD_ST_LOAD)
                   ? stab_cycles(ood_stab_sel_t'(HAS_OPT ? opt_mem[0][1:0] : 2'h3))
                   : stab_cycles(stab_sel);

  ood_stab_timer #(
    .CNT_W (CNT_W)
  ) u_stab (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (stab_start),
    .load_val (stab_load),
    .busy     (stab_busy),
    .done     (stab_done)
  );

  assign core_reset_n = (state_reg == OOD_ST_RUN) || (state_reg == OOD_ST_STOP) ||
                        (state_reg == OOD_ST_STAB && !por_pend_reg);
  assign stop_mode    = (state_reg == OOD_ST_STOP);
  assign osc_stable   = !stab_busy && (state_reg != OOD_ST_STOP);

  initial
  begin
    if (ROM_KB != 4 && ROM_KB != 8 && ROM_KB != 16 && ROM_KB != 32)
      $error("ood_top: ROM_KB must be 4, 8, 16 or 32");
    if (STAB_CYC0 < 1 || STAB_CYC1 < STAB_CYC0 || STAB_CYC2 < STAB_CYC1 || STAB_CYC3 < STAB_CYC2)
      $error("ood_top: stabilization counts must be ascending and nonzero");
  end

  // Unused-lint guard: por_en shown in OPT register only
  wire logic unused_ok;
  assign unused_ok = por_en;

endmodule // ood_top
`default_nettype wire

/* core/ood_map.svh */
// Address map, option bit layout and fixed counts of the option decoder.
// Assumes an AHB-Lite word bus and a 15-bit programmer address space.
`ifndef OOD_MAP_SVH
`define OOD_MAP_SVH

`define OOD_PADDR_W      15
`define OOD_PADDR_TOP    15'h7FFF
`define OOD_CADDR_TOP    16'hFFFF
`define OOD_OPT_BASE     15'h3FF0
`define OOD_OPT_LAST     15'h3FF6
`define OOD_OPT_NUM      7
`define OOD_ERASED       8'hFF

`define OOD_B0_CLK       4
`define OOD_B0_RSTO      3
`define OOD_B0_POR       2
`define OOD_P1_INV_MASK  8'hC0

`define OOD_REG_OPT      6'h00
`define OOD_REG_PULL     6'h04
`define OOD_REG_CTRL     6'h08
`define OOD_REG_STAT     6'h0C
`define OOD_REG_ROMA     6'h10
`define OOD_REG_ROMD     6'h14

`define OOD_CTRL_STOP    0
`define OOD_CTRL_SRST    1

`define OOD_RST_OUT_CYC  4'hF
`define OOD_HTRANS_NSEQ  2'h2
`define OOD_HSIZE_WORD   3'h2

`endif

/* core/ood_pkg.sv */
// Types shared by the option decoder files.
// Assumes ood_map.svh supplies all numeric constants.
package ood_pkg;

  // Gray coded along load, wait, run
  typedef enum logic [1:0] {
    OOD_ST_LOAD = 2'h0,
    OOD_ST_STAB = 2'h1,
    OOD_ST_RUN  = 2'h3,
    OOD_ST_STOP = 2'h2
  } ood_state_t;

  typedef enum logic [1:0] {
    OOD_STAB_2E4  = 2'h0,
    OOD_STAB_2E12 = 2'h1,
    OOD_STAB_2E16 = 2'h2,
    OOD_STAB_2E18 = 2'h3
  } ood_stab_sel_t;

endpackage

/* core/ood_stab_timer.sv */
// Down counter for the oscillation-stabilization wait.
// Assumes start is a one-cycle pulse with load_val at least one.
`timescale 1ns/1ps
`default_nettype none
module ood_stab_timer #(
  parameter int CNT_W = 19
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load_val,
  // Status
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             busy_reg;
  logic             busy_next;

  assign cnt_next  = start ? load_val : (busy_reg ? cnt_reg - 1'b1 : cnt_reg);
  assign busy_next = start | (busy_reg & (cnt_reg != {{(CNT_W-1){1'b0}}, 1'b1}));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy = busy_reg;
  assign done = busy_reg & ~busy_next;

  initial
  begin
    if (CNT_W < 2)
      $error("ood_stab_timer: CNT_W too small");
  end

endmodule // ood_stab_timer
`default_nettype wire

/* testbench/ood_top_assertions.sv */
// Checker for the option decoder top: bus answer, programmer reads, reset pin, stop and wake.
// Assumes it is bound into ood_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ood_top_checker #(
  parameter int ROM_KB = 16
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Programmer port
  input wire logic        prog_mode,
  input wire logic [14:0] prog_addr,
  input wire logic        prog_oe,
  input wire logic [7:0]  prog_rdata,
  // Reset pin and power state
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_o,
  input wire logic        rst_pin_oe,
  input wire logic        wake_req,
  input wire logic        stop_mode,
  input wire logic        osc_stable,
  input wire logic        core_reset_n,
  // Decoded options
  input wire logic        single_clock_sel,
  input wire logic [7:0]  port0_pullup_en,
  input wire logic [7:0]  port1_pullup_en,
  input wire logic [7:0]  port3_pullup_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [15:0] win_lo;
  logic        out_win;
  logic [24:0] opts;
  assign win_lo  = 16'h8000 - 16'(ROM_KB * 1024);
  assign out_win = prog_mode && prog_oe && ({1'b0, prog_addr} < win_lo) && !(prog_addr inside {[15'h3FF0:15'h3FF6]});
  assign opts    = {single_clock_sel, port0_pullup_en, port1_pullup_en, port3_pullup_en};

  a_bus_zero_wait: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait OKAY");
  a_prog_outside_ff: assert property (out_win |=> prog_rdata == 8'hFF)
    else $error("read outside the program window not erased value");
  a_prog_data_holds: assert property (!(prog_mode && prog_oe) |=> $stable(prog_rdata))
    else $error("programmer read data changed without a read");
  a_rst_pin_low: assert property (rst_pin_o == 1'b0) else $error("reset pin driven high");
  a_rst_pulse_len: assert property ($rose(rst_pin_oe) |-> rst_pin_oe[*8] ##1 rst_pin_oe[*7] ##1 !rst_pin_oe)
    else $error("reset pin pulse not 15 cycles");
  a_ext_reset_core: assert property (!rst_pin_i && !rst_pin_oe |-> ##[1:3] !core_reset_n)
    else $error("low reset pin did not hold core in reset");
  a_stop_no_clock: assert property (stop_mode |-> !osc_stable) else $error("stable flag set in stop");
  a_wake_waits: assert property (stop_mode && wake_req |=> !stop_mode && !osc_stable)
    else $error("wake skipped the stabilization wait");
  a_opts_only_reset: assert property (!$stable(opts) |-> !$past(core_reset_n))
    else $error("options changed outside reset");

  cover property (out_win);
  cover property ($rose(rst_pin_oe));
  cover property (stop_mode && wake_req);
endmodule // ood_top_checker

bind ood_top ood_top_checker #(.ROM_KB(ROM_KB)) chk_u (.*);
`default_nettype wire

/* testbench/ood_prog_model.sv */
// Byte-wide programmer model driving the PROM port of the option decoder.
// Assumes the port is synchronous to hclk; tasks are called from the bench.
`timescale 1ns/1ps
`default_nettype none
module ood_prog_model (
  // Clock
  input wire logic        hclk,
  // Programmer port
  output logic            prog_mode,
  output logic [14:0]     prog_addr,
  output logic [7:0]      prog_wdata,
  output logic            prog_we,
  output logic            prog_oe,
  input wire logic [7:0]  prog_rdata
);
  initial
  begin
    prog_mode  = 1'b0;
    prog_addr  = 15'h0000;
    prog_wdata = 8'h00;
    prog_we    = 1'b0;
    prog_oe    = 1'b0;
  end

  task automatic set_mode(input logic m);
    @(posedge hclk);
    prog_mode <= m;
  endtask

  // Option bytes and image go through the same byte write; any address up to 7FFF
  task automatic pwrite(input logic [14:0] a, input logic [7:0] d);
    @(posedge hclk);
    prog_addr  <= a;
    prog_wdata <= d;
    prog_we    <= 1'b1;
    @(posedge hclk);
    prog_we    <= 1'b0;
    // Released data shows no stale byte
    prog_wdata <= ~d;
  endtask

  // Plain read only, no identification query
  task automatic pread(input logic [14:0] a, output logic [7:0] d);
    @(posedge hclk);
    prog_addr <= a;
    prog_oe   <= 1'b1;
    @(posedge hclk);
    prog_oe   <= 1'b0;
    @(posedge hclk);
    d = prog_rdata;
  endtask
endmodule // ood_prog_model
`default_nettype wire

/* testbench/ood_top_tb_top.sv */
// Self-checking bench: option decode, PROM window, reset pin, stop and wake.
// Assumes ood_top, its checker and the programmer model are compiled before.
`timescale 1ns/1ps
`default_nettype none
`include "ood_map.svh"
module ood_top_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sz;
  logic        prog_mode, prog_we, prog_oe, rst_pin_i, rst_pin_o, rst_pin_oe, ext_rst;
  logic [14:0] prog_addr;
  logic [7:0]  prog_wdata, prog_rdata, b;
  logic        wdt_reset_req, wake_req, single_clock_sel, core_reset_n, stop_mode, osc_stable;
  logic [7:0]  port0_pullup_en, port1_pullup_en, port3_pullup_en;
  int          fail_count, n_compared, n;
  logic [7:0]  opt [7] = '{8'h0D, 8'hA5, 8'h5A, 8'h3C, 8'h00, 8'h00, 8'h00};

  // Open drain pin with pull-up
  assign rst_pin_i = ~(rst_pin_oe | ext_rst);
  assign hready    = hreadyout;

  ood_top #(.STAB_CYC0(4), .STAB_CYC1(8), .STAB_CYC2(16), .STAB_CYC3(32)) dut_u (.*);
  ood_prog_model prog_u (.*);

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_hi(input int s);
    int  k;
    logic v;
    k = 0;
    v = 1'b0;
    while (v !== 1'b1 && k < 300)
    begin
      @(posedge hclk);
      k++;
      v = (s == 0) ? core_reset_n : (s == 1) ? osc_stable : (s == 2) ? !rst_pin_oe : hready;
    end
    if (v !== 1'b1)
    begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    htrans <= `OOD_HTRANS_NSEQ;
    hwrite <= w;
    hsize  <= sz;
    wait_hi(3);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hi(3);
    r = hrdata;
  endtask

  initial
  begin
    {hresetn, hsel, hwrite, ext_rst, wdt_reset_req, wake_req} = '0;
    {haddr, hwdata, htrans, hsize, fail_count, n_compared} = '0;
    sz = `OOD_HSIZE_WORD;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `OOD_REG_OPT, 0, rd); chk(rd, 32'h1F);
    ahb(0, `OOD_REG_PULL, 0, rd); chk(rd, 32'h00FF3FFF);
    ahb(0, `OOD_REG_STAT, 0, rd); chk(rd, 32'h1);
    wait_hi(0);
    ahb(0, `OOD_REG_STAT, 0, rd); chk(rd, 32'hF);
    prog_u.set_mode(1'b1);
    for (int i = 0; i < 7; i++) prog_u.pwrite(`OOD_OPT_BASE + 15'(i), opt[i]);
    prog_u.pwrite(15'h4000, 8'h12);
    prog_u.pwrite(15'h7FFF, 8'h34);
    prog_u.pwrite(15'h3FFF, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      prog_u.pread(`OOD_OPT_BASE + 15'(i), b); chk({24'h0, b}, {24'h0, opt[i]});
    end
    prog_u.pread(15'h3FFF, b); chk({24'h0, b}, 32'hFF);
    prog_u.pread(15'h4000, b); chk({24'h0, b}, 32'h12);
    prog_u.pread(15'h7FFF, b); chk({24'h0, b}, 32'h34);
    prog_u.set_mode(1'b0);
    ahb(1, `OOD_REG_ROMA, 32'hC000, rd); ahb(0, `OOD_REG_ROMD, 0, rd); chk(rd, 32'h12);
    ahb(1, `OOD_REG_ROMA, 32'hFFFF, rd); ahb(0, `OOD_REG_ROMD, 0, rd); chk(rd, 32'h34);
    ahb(1, `OOD_REG_ROMA, 32'hBFFF, rd); ahb(0, `OOD_REG_ROMD, 0, rd); chk(rd, 32'hFF);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    wait_hi(0);
    ahb(0, `OOD_REG_OPT, 0, rd); chk(rd, 32'h0D);
    ahb(0, `OOD_REG_PULL, 0, rd); chk(rd, 32'h003C9AA5);
    chk({23'h0, single_clock_sel, port1_pullup_en}, 32'h9A);
    chk({port0_pullup_en, port3_pullup_en}, 32'hA53C);
    ahb(0, 6'h20, 0, rd); chk(rd, 32'h0);
    // Byte access is not served and reads zero
    sz = 3'h0;
    ahb(0, `OOD_REG_OPT, 0, rd); chk(rd, 32'h0);
    sz = `OOD_HSIZE_WORD;
    ahb(1, `OOD_REG_OPT, 0, rd); ahb(0, `OOD_REG_OPT, 0, rd); chk(rd, 32'h0D);
    ahb(1, `OOD_REG_CTRL, 32'h1, rd);
    repeat (2) @(posedge hclk);
    chk({stop_mode, osc_stable}, 2'b10);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    n = 0;
    while (osc_stable !== 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    // Wait length of code 01 plus sequencing latency
    chk(32'(n >= 8 && n <= 12), 32'h1);
    wdt_reset_req <= 1'b1;
    @(posedge hclk);
    wdt_reset_req <= 1'b0;
    @(posedge hclk);
    @(posedge hclk);
    chk({31'h0, rst_pin_oe}, 32'h1);
    wait_hi(2);
    wait_hi(0);
    ext_rst <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({31'h0, core_reset_n}, 32'h0);
    ext_rst <= 1'b0;
    wait_hi(0);
    final_report();
  end
endmodule // ood_top_tb_top
`default_nettype wire
